//--- rtl/ocp_top.sv
// How it works
// - Control bits 2..0 equal 111 select one-shot pulse generation.
// - Bit 3 set drives output high when active, low when not.
// - Bits 5..4 equal 10 make pause asserted on a high input.
// - Bits 7..6 equal 01 enable the external clock line.
// - Bits 9..8 equal 10 enable trigger, active on a high level.
// - Bits 12..10 equal 101 count on the external clock.
// - Bit 13 clear bypasses debounce on pause and trigger inputs.
// - Bit 14 set makes the counter 32 bits instead of 16.
// - Interrupt reaches host only if bit 15 and board enable set.
// - First count gives non-active length, second count the active length.
// - Pause freezes counter and output; release resumes them.
// - Pause and trigger pins are sampled and synchronised on internal clock.
// - A 32-bit channel takes over the next channel.
// - Control register sits at offset 48h.
`timescale 1ns/1ps
module ocp_top import ocp_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic channel_clock_pin_i,
   input wire logic channel_pause_pin_i,
   input wire logic channel_trigger_pin_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic channel_output_o,
   output logic irq_o,
   output logic pair_busy_o
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic board_ie;
      logic [31:0] first;
      logic [31:0] second;
      logic [31:0] rdata;
      logic start_tgl;
      logic [31:0] sh_first;
      logic [31:0] sh_second;
      logic sh_pol;
      logic sh_wide;
      logic [8:0] pdeb;
      logic [8:0] tdeb;
      logic pause_f;
      logic trig_f;
      logic trig_d;
      logic pause_on;
      logic out;
      logic irq;
      logic pair;
   } ocp_top_s;

   ocp_top_s r;
   ocp_top_s next_r;
   ocp_link_if lk ();
   logic [1:0] pin_s;
   logic [2:0] st_s;
   logic st_ack;
   logic st_run;
   logic st_out;
   logic busy;
   logic armed;
   logic trig_act;
   logic ext_edge;
   logic sw_trig;
   logic start;

   ////////////////////////////////////////////////////////////////////////////
   // Pin inputs into the internal clock domain
   ocp_sync #(.W(2)) u_pins (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i({channel_pause_pin_i, channel_trigger_pin_i}),
      .q_o(pin_s)
   );

   // Engine state back from the link domain
   ocp_sync #(.W(3)) u_stat (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i({lk.ack_tgl, lk.run, lk.out_lvl}),
      .q_o(st_s)
   );
   assign st_ack = st_s[2];
   assign st_run = st_s[1];
   assign st_out = st_s[0];

   ocp_engine u_eng (
      .clk_link_i(channel_clock_pin_i),
      .rst_b_i(rst_b_i),
      .lk(lk.eng)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Debounce: level must hold for the debounce time before it is taken
   function automatic logic [9:0] deb_step(input logic raw, input logic filt,
         input logic [8:0] cnt, input logic en);
      logic [9:0] res;
      res = {filt, 9'h000};
      if (!en) begin
         res = {raw, 9'h000};
      end else if (raw != filt) begin
         if (cnt == DEB_LAST) res = {raw, 9'h000};
         else res = {filt, cnt + 9'h001};
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Trigger qualification
   always_comb begin
      unique case (r.ctrl[TRIG_LSB +: 2])
         LVL_HIGH: trig_act = r.trig_f;
         LVL_LOW: trig_act = !r.trig_f;
         default: trig_act = 1'b0;
      endcase
   end

   // Busy until the engine has taken the start and finished its run
   assign busy = (r.start_tgl != st_ack) || st_run;
   assign armed = (r.ctrl[MODE_LSB +: 3] == MODE_ONE_SHOT)
      && (r.ctrl[EXTCLK_LSB +: 2] == EXTCLK_ON)
      && (r.ctrl[CLKSEL_LSB +: 3] == CLK_EXT)
      && !busy;
   assign ext_edge = trig_act && !r.trig_d;
   assign sw_trig = reg_wr_i && reg_addr_i == OFS_TRIGGER && reg_wdata_i[SW_TRIG_BIT];
   assign start = armed && (sw_trig || ext_edge);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [9:0] pstep;
      logic [9:0] tstep;
      pstep = deb_step(pin_s[1], r.pause_f, r.pdeb, r.ctrl[DEB_BIT]);
      tstep = deb_step(pin_s[0], r.trig_f, r.tdeb, r.ctrl[DEB_BIT]);
      next_r = r;
      next_r.pause_f = pstep[9];
      next_r.pdeb = pstep[8:0];
      next_r.trig_f = tstep[9];
      next_r.tdeb = tstep[8:0];
      next_r.trig_d = trig_act;

      unique case (r.ctrl[PAUSE_LSB +: 2])
         LVL_HIGH: next_r.pause_on = r.pause_f;
         LVL_LOW: next_r.pause_on = !r.pause_f;
         default: next_r.pause_on = 1'b0;
      endcase

      // Register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            OFS_BOARD_IE: next_r.board_ie = reg_wdata_i[BOARD_IE_BIT];
            OFS_CONTROL: next_r.ctrl = reg_wdata_i[15:0];
            OFS_FIRST: next_r.first = reg_wdata_i;
            OFS_SECOND: next_r.second = reg_wdata_i;
            default: next_r.ctrl = r.ctrl;
         endcase
      end

      // Register reads; unmapped offsets read zero
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_BOARD_IE: next_r.rdata = {31'h0000_0000, r.board_ie};
            OFS_CONTROL: next_r.rdata = {16'h0000, r.ctrl};
            OFS_FIRST: next_r.rdata = r.first;
            OFS_SECOND: next_r.rdata = r.second;
            OFS_STATUS: next_r.rdata = {29'h0000_0000, r.out, busy, st_run};
            default: next_r.rdata = 32'h0000_0000;
         endcase
      end

      // Shadow counts stay still until the engine has taken them
      if (start) begin
         next_r.start_tgl = !r.start_tgl;
         next_r.sh_first = r.first;
         next_r.sh_second = r.second;
         next_r.sh_pol = r.ctrl[POL_BIT];
         next_r.sh_wide = r.ctrl[WIDE_BIT];
      end

      // Idle shows the non-active level of the current polarity
      next_r.out = st_run ? st_out : !r.ctrl[POL_BIT];
      next_r.irq = (next_r.out != r.out) && r.ctrl[IE_BIT] && r.board_ie;
      next_r.pair = r.ctrl[WIDE_BIT];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         r <= '0;
         r.ctrl <= CTRL_RESET;
         r.first <= COUNT_RESET;
         r.second <= COUNT_RESET;
         r.out <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign lk.start_tgl = r.start_tgl;
   assign lk.first_cnt = r.sh_first;
   assign lk.second_cnt = r.sh_second;
   assign lk.pol = r.sh_pol;
   assign lk.wide = r.sh_wide;
   assign lk.pause_lvl = r.pause_on;
   assign reg_rdata_o = r.rdata;
   assign channel_output_o = r.out;
   assign irq_o = r.irq;
   assign pair_busy_o = r.pair;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence start_seen_s;
      $changed(r.start_tgl);
   endsequence

   mode_gate_a: assert property (start_seen_s |-> $past(r.ctrl[MODE_LSB +: 3]) == MODE_ONE_SHOT)
      else $error("start issued outside one-shot mode");
   ext_clock_a: assert property (start_seen_s |-> $past(r.ctrl[EXTCLK_LSB +: 2]) == EXTCLK_ON)
      else $error("start issued with external clock disabled");
   clk_sel_a: assert property (start_seen_s |-> $past(r.ctrl[CLKSEL_LSB +: 3]) == CLK_EXT)
      else $error("start issued without external clock source");
   trig_start_a: assert property ((armed && (sw_trig || ext_edge)) |=> start_seen_s ##1 !start_seen_s)
      else $error("trigger did not start the engine once");
   trig_high_a: assert property ((r.ctrl[TRIG_LSB +: 2] == LVL_HIGH && armed && $rose(r.trig_f))
      |=> start_seen_s)
      else $error("high trigger level ignored");
   pause_high_a: assert property ((r.ctrl[PAUSE_LSB +: 2] == LVL_HIGH && r.pause_f) |=> r.pause_on)
      else $error("high pause level not asserted");
   deb_bypass_a: assert property ((!r.ctrl[DEB_BIT] && $stable(r.ctrl)) |=> r.trig_f == $past(pin_s[0])
      && r.pause_f == $past(pin_s[1]))
      else $error("bypass did not pass synchronised pins");
   irq_gate_a: assert property (irq_o |-> $past(r.ctrl[IE_BIT]) && $past(r.board_ie))
      else $error("interrupt without both enables");
   irq_edge_a: assert property (($changed(channel_output_o) && $past(r.ctrl[IE_BIT] && r.board_ie)) |-> irq_o)
      else $error("output edge raised no interrupt");
   idle_level_a: assert property (!st_run |=> channel_output_o == !$past(r.ctrl[POL_BIT]))
      else $error("idle output not at non-active level");
   count_write_a: assert property ((reg_wr_i && reg_addr_i == OFS_FIRST) |=> r.first == $past(reg_wdata_i))
      else $error("first phase count not written");
   ctrl_write_a: assert property ((reg_wr_i && reg_addr_i == OFS_CONTROL) |=> r.ctrl == $past(reg_wdata_i[15:0]))
      else $error("control register not written at its offset");
   pair_flag_a: assert property ($rose(r.ctrl[WIDE_BIT]) |=> pair_busy_o)
      else $error("next channel not flagged as taken");
endmodule

//--- rtl/ocp_pkg.sv
package ocp_pkg;
   localparam int unsigned CLK_PERIOD_NS = 5;
   // Register offsets
   localparam logic [7:0] OFS_BOARD_IE = 8'h00;
   localparam logic [7:0] OFS_TRIGGER = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CONTROL = 8'h48;
   localparam logic [7:0] OFS_FIRST = 8'h7c;
   localparam logic [7:0] OFS_SECOND = 8'h94;
   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   // Control field positions
   localparam int MODE_LSB = 0;
   localparam int POL_BIT = 3;
   localparam int PAUSE_LSB = 4;
   localparam int EXTCLK_LSB = 6;
   localparam int TRIG_LSB = 8;
   localparam int CLKSEL_LSB = 10;
   localparam int DEB_BIT = 13;
   localparam int WIDE_BIT = 14;
   localparam int IE_BIT = 15;
   localparam int BOARD_IE_BIT = 0;
   localparam int SW_TRIG_BIT = 0;
   // Control field codes
   localparam logic [2:0] MODE_ONE_SHOT = 3'h7;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   localparam logic [1:0] LVL_LOW = 2'h1;
   localparam logic [1:0] EXTCLK_ON = 2'h1;
   localparam logic [2:0] CLK_EXT = 3'h5;
   // Input debounce time
   localparam int unsigned DEBOUNCE_NS = 2400;
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] DEB_LAST = 9'(DEBOUNCE_CYC - 1);
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WAIT = 2'b01,
      PH_ACTIVE = 2'b10
   } ocp_phase_e;
endpackage

//--- rtl/ocp_link_if.sv
`timescale 1ns/1ps
interface ocp_link_if;
   logic start_tgl;
   logic [31:0] first_cnt;
   logic [31:0] second_cnt;
   logic pol;
   logic wide;
   logic pause_lvl;
   logic ack_tgl;
   logic run;
   logic active;
   logic out_lvl;
   modport ctl (output start_tgl, first_cnt, second_cnt, pol, wide, pause_lvl,
      input ack_tgl, run, active, out_lvl);
   modport eng (input start_tgl, first_cnt, second_cnt, pol, wide, pause_lvl,
      output ack_tgl, run, active, out_lvl);
endinterface

//--- rtl/ocp_sync.sv
`timescale 1ns/1ps
module ocp_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } ocp_sync_s;
   ocp_sync_s r;
   ocp_sync_s next_r;
   always_comb begin
      next_r.meta = d_i;
      next_r.q = r.meta;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) r <= '0;
      else r <= next_r;
   end
   assign q_o = r.q;
endmodule

//--- rtl/ocp_engine.sv
`timescale 1ns/1ps
module ocp_engine import ocp_pkg::*; (
   input wire logic clk_link_i,
   input wire logic rst_b_i,
   ocp_link_if.eng lk
);
   typedef struct packed {
      logic tgl_seen;
      ocp_phase_e phase;
      logic [31:0] cnt;
      logic [31:0] second;
      logic pol;
      logic out;
   } ocp_eng_s;
   ocp_eng_s r;
   ocp_eng_s next_r;
   logic rst_lk_b;
   logic [1:0] in_s;
   logic start;
   logic pause;

   ocp_sync #(.W(1)) u_rst (.clk_i(clk_link_i), .rst_b_i(1'b1), .d_i(rst_b_i), .q_o(rst_lk_b));
   ocp_sync #(.W(2)) u_in (.clk_i(clk_link_i), .rst_b_i(rst_lk_b),
      .d_i({lk.start_tgl, lk.pause_lvl}), .q_o(in_s));

   assign start = in_s[1] != r.tgl_seen;
   assign pause = in_s[0];

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      if (start) begin
         next_r.tgl_seen = in_s[1];
         next_r.phase = PH_WAIT;
         next_r.cnt = lk.wide ? lk.first_cnt : {16'h0000, lk.first_cnt[15:0]};
         next_r.second = lk.wide ? lk.second_cnt : {16'h0000, lk.second_cnt[15:0]};
         next_r.pol = lk.pol;
      end else if (!pause && r.phase != PH_IDLE) begin
         if (r.cnt <= 32'h0000_0001) begin
            if (r.phase == PH_WAIT) begin
               next_r.phase = PH_ACTIVE;
               next_r.cnt = r.second;
            end else begin
               next_r.phase = PH_IDLE;
            end
         end else begin
            next_r.cnt = r.cnt - 32'h0000_0001;
         end
      end
      next_r.out = (next_r.phase == PH_ACTIVE) ~^ next_r.pol;
   end
   always_ff @(posedge clk_link_i) begin
      if (!rst_lk_b) r <= '0;
      else r <= next_r;
   end
   assign lk.ack_tgl = r.tgl_seen;
   assign lk.run = r.phase != PH_IDLE;
   assign lk.active = r.phase == PH_ACTIVE;
   assign lk.out_lvl = r.out;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_link_i); endclocking
   default disable iff (!rst_lk_b);
   sequence wait_end_s;
      r.phase == PH_WAIT && r.cnt <= 32'h0000_0001 && !pause && !start;
   endsequence
   sequence active_end_s;
      r.phase == PH_ACTIVE && r.cnt <= 32'h0000_0001 && !pause && !start;
   endsequence
   phase_order_a: assert property (wait_end_s |=> r.phase == PH_ACTIVE && r.cnt == $past(r.second))
      else $error("waiting phase did not hand over to active phase");
   one_shot_end_a: assert property (active_end_s |=> r.phase == PH_IDLE ##1 (r.phase == PH_IDLE || $past(start)))
      else $error("one-shot ran past its active phase");
   pause_hold_a: assert property ((pause && !start && r.phase != PH_IDLE) |=> $stable(r.cnt) && $stable(r.out))
      else $error("count or output moved during pause");
   width_cut_a: assert property ((start && !lk.wide) |=> r.cnt[31:16] == 16'h0000)
      else $error("narrow count kept upper bits");
   active_level_a: assert property (r.phase == PH_ACTIVE |-> r.out == r.pol)
      else $error("active phase level wrong");
endmodule

//--- tb/ocp_field_model.sv
`timescale 1ns/1ps
module ocp_field_model (
   input wire logic run_i,
   input wire logic pause_i,
   input wire logic trig_i,
   output logic ext_clk_o,
   output logic pause_o,
   output logic trig_o
);
   // External clock toggles only inside frames and rests low otherwise
   initial begin
      ext_clk_o = 1'b0;
      #1.3;
      forever begin
         #16;
         ext_clk_o = run_i ? ~ext_clk_o : 1'b0;
      end
   end
   // Pause and trigger are plain field levels, driven hard both ways
   assign pause_o = pause_i;
   assign trig_o = trig_i;
endmodule

//--- tb/tb_counter_one_shot_pulse.sv
`timescale 1ns/1ps
module tb_counter_one_shot_pulse import ocp_pkg::*; ;
   logic clk_i, rst_b_i, reg_wr, reg_rd, out_o, irq, pair_busy, link_run, pause_pin, trig_pin;
   logic ext_clk, pause_w, trig_w;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, rdata, d;
   int errors, n_checks;
   ocp_field_model u_field (.run_i(link_run), .pause_i(pause_pin), .trig_i(trig_pin),
      .ext_clk_o(ext_clk), .pause_o(pause_w), .trig_o(trig_w));
   ocp_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .channel_clock_pin_i(ext_clk),
      .channel_pause_pin_i(pause_w), .channel_trigger_pin_i(trig_w), .reg_addr_i(reg_addr),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
      .channel_output_o(out_o), .irq_o(irq), .pair_busy_o(pair_busy));
   always #2.5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      if (errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_i);
      reg_wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_i);
      reg_rd <= 1'b0;
      @(posedge clk_i);
      check(rdata, exp, what);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // One triggered waveform: counts cycles at the active level and interrupt pulses
   task automatic one_run(input bit pin, input logic act, input int lo, input int hi, input int nirq,
         input int pz);
      int na, ni, k, extra;
      na = 0;
      ni = 0;
      k = 0;
      extra = 0;
      link_run <= 1'b1;
      if (pin) begin
         trig_pin <= 1'b1;
         @(posedge clk_i);
      end else begin
         wr_reg(OFS_TRIGGER, 32'h1);
      end
      if (pz > 0) begin
         repeat (20) @(posedge clk_i);
         pause_pin <= 1'b1;
         repeat (pz) begin
            @(posedge clk_i);
            if (out_o === act) na++;
         end
         check(32'(na), 32'h0, "paused_active");
         rc(OFS_STATUS, 32'h3, "paused_status");
         pause_pin <= 1'b0;
      end
      while (k < 3000 && !(na > 0 && out_o === ~act)) begin
         @(posedge clk_i);
         k++;
         if (out_o === act) na++;
         if (irq === 1'b1) ni++;
      end
      if (k >= 3000) begin
         check(32'h0, 32'h1, "run_timeout");
         end_of_test();
      end
      repeat (120) begin
         @(posedge clk_i);
         if (out_o === act) extra++;
         if (irq === 1'b1) ni++;
      end
      check({31'h0, na >= lo && na <= hi}, 32'h1, "active_cycles");
      check(32'(ni), 32'(nirq), "irq_count");
      check(32'(extra), 32'h0, "no_second_pulse");
      rc(OFS_STATUS, {29'h0, ~act, 2'h0}, "idle_status");
      trig_pin <= 1'b0;
      link_run <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic regs_test;
      check({31'h0, pair_busy}, 32'h0, "pair_reset");
      rc(OFS_CONTROL, {16'h0, CTRL_RESET}, "ctrl_reset");
      rc(OFS_FIRST, COUNT_RESET, "first_reset");
      wr_reg(OFS_CONTROL, 32'h0000_d66f);
      rc(OFS_CONTROL, 32'h0000_d66f, "ctrl_rb");
      check({31'h0, pair_busy}, 32'h1, "pair_busy");
      wr_reg(OFS_FIRST, 32'h4);
      wr_reg(OFS_SECOND, 32'h1);
      rc(OFS_FIRST, 32'h4, "first_rb");
      rc(OFS_SECOND, 32'h1, "second_rb");
      rc(8'h20, 32'h0, "unmapped");
      rc(OFS_TRIGGER, 32'h0, "trig_reads_0");
   endtask
   task automatic irq_gate_test;
      wr_reg(OFS_BOARD_IE, 32'h0);
      one_run(1'b0, 1'b1, 4, 9, 0, 0);
      wr_reg(OFS_BOARD_IE, 32'h1);
      wr_reg(OFS_CONTROL, 32'h0000_566f);
      one_run(1'b0, 1'b1, 4, 9, 0, 0);
      wr_reg(OFS_CONTROL, 32'h0000_d66f);
   endtask
   task automatic refuse_test;
      logic [15:0] codes[3];
      codes = '{16'hd66e, 16'hd26f, 16'hd62f};
      link_run <= 1'b1;
      foreach (codes[i]) begin
         wr_reg(OFS_CONTROL, {16'h0, codes[i]});
         wr_reg(OFS_TRIGGER, 32'h1);
         repeat (60) @(posedge clk_i);
         rc(OFS_STATUS, 32'h0, "refused_start");
      end
      link_run <= 1'b0;
   endtask
   task automatic debounce_test;
      wr_reg(OFS_CONTROL, 32'h0000_f66f);
      link_run <= 1'b1;
      trig_pin <= 1'b1;
      repeat (100) @(posedge clk_i);
      trig_pin <= 1'b0;
      repeat (600) @(posedge clk_i);
      rc(OFS_STATUS, 32'h0, "glitch_filtered");
      link_run <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      rst_b_i = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      link_run = 1'b1;
      pause_pin = 1'b0;
      trig_pin = 1'b0;
      errors = 0;
      n_checks = 0;
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      // Keep the link clock running until the engine's reset synchroniser has seen three edges
      repeat (16) @(posedge clk_i);
      link_run <= 1'b0;
      @(posedge clk_i);
      regs_test();
      wr_reg(OFS_BOARD_IE, 32'h1);
      // 4 and 1 link periods of 32 ns: about 6.4 cycles active
      one_run(1'b0, 1'b1, 4, 9, 2, 0);
      irq_gate_test();
      one_run(1'b1, 1'b1, 4, 9, 2, 0);
      debounce_test();
      wr_reg(OFS_CONTROL, 32'h0000_d66f);
      wr_reg(OFS_FIRST, 32'h8);
      one_run(1'b0, 1'b1, 4, 9, 2, 200);
      refuse_test();
      // Narrow counter, active low: only 16'h0002 of the second count is used
      wr_reg(OFS_CONTROL, 32'h0000_9667);
      wr_reg(OFS_SECOND, 32'h0001_0002);
      check({31'h0, pair_busy}, 32'h0, "pair_free");
      one_run(1'b0, 1'b0, 10, 16, 2, 0);
      end_of_test();
   end
endmodule
